// >>> hdl/tfs_pkg.sv
package tfs_pkg;
    // Host bus decode of the command block.
    localparam logic [1:0] CS_CMD_BLK     = 2'h2;
    localparam logic [2:0] DA_FEATURE     = 3'h1;
    localparam logic [2:0] DA_SECT_COUNT  = 3'h2;
    localparam logic [2:0] DA_SECT_NUMBER = 3'h3;
    localparam logic [2:0] DA_STATUS      = 3'h7;

    // Status bit positions.
    localparam int ST_BUSY_BIT  = 7;
    localparam int ST_READY_BIT = 6;
    localparam int ST_FAULT_BIT = 5;
    localparam int ST_SEEK_BIT  = 4;
    localparam int ST_DREQ_BIT  = 3;
    localparam int ST_CORRECTED_DATA_FLAG_BIT  = 2;
    localparam int ST_INDEX_BIT = 1;
    localparam int ST_ERROR_BIT = 0;

    // Reset values.
    localparam logic [7:0] REG_RESET_VAL   = 8'h00;
    localparam logic [7:0] COUNT_RESET_VAL = 8'h01;
    localparam logic [7:0] SECT_RESET_VAL  = 8'h01;
    localparam logic [7:0] ERRREG_RESET    = 8'h01;

    // A count of zero stands for this many sectors.
    localparam logic [8:0] FULL_SECT_COUNT = 9'h100;

    // Timing.
    localparam int CLK_PERIOD_NS = 8;
    localparam int BUSY_MAX_NS   = 400;
    localparam int BUSY_MAX_CYC  = BUSY_MAX_NS / CLK_PERIOD_NS;
    localparam int RESET_HOLD_CYC = 16;

    typedef enum logic [1:0] {
        TFS_RESET,
        TFS_IDLE,
        TFS_BUSY,
        TFS_XFER
    } tfs_state_t;
endpackage

// >>> hdl/tfs_sync.sv
`timescale 1ns/1ps
// Two flip-flop synchroniser for a group of pin inputs.
module tfs_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset.
    input  wire logic             ref_clk_i,
    input  wire logic             rstn_i,
    // Data.
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;
endmodule

// >>> hdl/tfs_flag_hold.sv
`timescale 1ns/1ps
// Status flag that follows a live level until locked, then holds until
// the host reads status.
module tfs_flag_hold #(
    parameter bit LOCK_ON_CHANGE = 1'b0
) (
    // Clock and reset.
    input  wire logic ref_clk_i,
    input  wire logic rstn_i,
    // Control.
    input  wire logic live_i,
    input  wire logic freeze_i,
    input  wire logic status_read_i,
    // Result.
    output logic      flag_o
);
    logic flag_q;
    logic lock_q;
    logic change;
    logic lock_set;

    assign change   = (live_i != flag_q) && !lock_q;
    assign lock_set = freeze_i || (LOCK_ON_CHANGE && change);

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            flag_q <= 1'b0;
            lock_q <= 1'b0;
        end else begin
            if (!lock_q) begin
                flag_q <= live_i;
            end
            // A new lock in the read cycle wins over the unlock.
            lock_q <= lock_set || (lock_q && !status_read_i);
        end
    end

    assign flag_o = flag_q;
endmodule

// >>> hdl/tfs_task_file.sv
`timescale 1ns/1ps
module tfs_task_file
    import tfs_pkg::*;
#(
    parameter int RESET_HOLD = tfs_pkg::RESET_HOLD_CYC
) (
    // Clock and reset.
    input  wire logic       ref_clk_i,
    input  wire logic       rstn_i,
    // Host bus pins.
    input  wire logic [1:0] host_cs_i,
    input  wire logic [2:0] host_da_i,
    input  wire logic       host_rd_i,
    input  wire logic       host_wr_i,
    input  wire logic [7:0] host_dd_i,
    output logic      [7:0] host_dd_o,
    output logic            host_dd_oe_o,
    output logic            host_intrq_o,
    // Device control and device/head inputs.
    input  wire logic       soft_reset_i,
    input  wire logic       lba_mode_i,
    // Device core levels.
    input  wire logic       core_ready_i,
    input  wire logic       core_fault_i,
    input  wire logic       core_seek_done_i,
    input  wire logic       core_corrected_i,
    input  wire logic       core_index_i,
    // Device core events.
    input  wire logic       core_block_ready_i,
    input  wire logic       core_block_taken_i,
    input  wire logic       core_last_block_i,
    input  wire logic       core_dir_in_i,
    input  wire logic       core_done_i,
    input  wire logic       core_error_i,
    input  wire logic [7:0] core_error_code_i,
    input  wire logic [7:0] core_left_count_i,
    input  wire logic [7:0] core_error_sector_i,
    // Command to the device core.
    output logic            cmd_valid_o,
    output logic      [7:0] cmd_code_o,
    output logic      [7:0] cmd_feature_o,
    output logic      [8:0] cmd_count_o,
    output logic      [7:0] cmd_sector_o,
    output logic            cmd_lba_o,
    // Status view.
    output logic            busy_o,
    output logic            data_request_o
);
    import tfs_pkg::*;

    localparam logic [7:0] HOLD_LAST = 8'(RESET_HOLD - 1);

    logic [1:0] cs_s;
    logic [2:0] da_s;
    logic       rd_s;
    logic       wr_s;
    logic [7:0] dd_s;
    logic       rd_dly_q;
    logic       wr_dly_q;

    tfs_state_t state_q;
    tfs_state_t state_d;
    logic [7:0] hold_cnt_q;
    logic [7:0] feature_q;
    logic [7:0] count_q;
    logic [7:0] sector_q;
    logic [7:0] err_code_q;
    logic       err_q;
    logic       intr_q;
    logic [7:0] rdata_q;
    logic       cmd_valid_q;
    logic [7:0] cmd_code_q;
    logic [7:0] cmd_feature_q;
    logic [8:0] cmd_count_q;
    logic [7:0] cmd_sector_q;
    logic       cmd_lba_q;

    logic       busy;
    logic       data_request_flag;
    logic       sel;
    logic       rd_ev;
    logic       wr_ev;
    logic       wr_ok;
    logic       wr_cmd;
    logic       wr_feat;
    logic       wr_count;
    logic       wr_sect;
    logic       rd_status;
    logic       done_ev;
    logic       done_err;
    logic       blk_ready;
    logic       final_in;
    logic       blk_next;
    logic       ready_flag;
    logic       seek_flag;
    logic       hold_done;
    logic [7:0] status;
    logic [7:0] rd_mux;
    logic       rd_hit;

    function automatic logic [8:0] sect_total(input logic [7:0] cnt);
        sect_total = (cnt == 8'h00) ? FULL_SECT_COUNT : {1'b0, cnt};
    endfunction

    tfs_sync #(
        .WIDTH (15)
    ) u_sync (
        .ref_clk_i (ref_clk_i),
        .rstn_i    (rstn_i),
        .async_i   ({host_cs_i, host_da_i, host_rd_i, host_wr_i, host_dd_i}),
        .sync_o    ({cs_s, da_s, rd_s, wr_s, dd_s})
    );

    // Strobe edges and address decode.
    assign sel       = (cs_s == CS_CMD_BLK);
    assign rd_ev     = rd_s && !rd_dly_q && sel;
    assign wr_ev     = wr_s && !wr_dly_q && sel;
    assign busy      = (state_q == TFS_RESET) || (state_q == TFS_BUSY);
    assign data_request_flag       = (state_q == TFS_XFER);
    assign wr_ok     = wr_ev && !busy && !data_request_flag;
    assign wr_cmd    = wr_ok && (da_s == DA_STATUS);
    assign wr_feat   = wr_ok && (da_s == DA_FEATURE);
    assign wr_count  = wr_ok && (da_s == DA_SECT_COUNT);
    assign wr_sect   = wr_ok && (da_s == DA_SECT_NUMBER);
    assign rd_status = rd_ev && (da_s == DA_STATUS);

    // Core events are honoured only in the states that own them.
    assign done_ev   = core_done_i && (state_q == TFS_BUSY);
    assign done_err  = done_ev && core_error_i;
    assign blk_ready = core_block_ready_i && (state_q == TFS_BUSY);
    assign final_in  = core_block_taken_i && (state_q == TFS_XFER)
                       && core_last_block_i && core_dir_in_i;
    assign blk_next  = core_block_taken_i && (state_q == TFS_XFER)
                       && !final_in;
    assign hold_done = (hold_cnt_q == HOLD_LAST) && !soft_reset_i;

    // Busy and data request sequencing.
    always_comb begin
        state_d = state_q;
        case (state_q)
            TFS_RESET: begin
                if (hold_done) begin
                    state_d = TFS_IDLE;
                end
            end
            TFS_IDLE: begin
                // Any code is taken regardless of ready.
                if (wr_cmd) begin
                    state_d = TFS_BUSY;
                end
            end
            TFS_BUSY: begin
                if (blk_ready) begin
                    state_d = TFS_XFER;
                end else if (done_ev) begin
                    state_d = TFS_IDLE;
                end
            end
            TFS_XFER: begin
                if (final_in) begin
                    state_d = TFS_IDLE;
                end else if (blk_next) begin
                    state_d = TFS_BUSY;
                end
            end
            default: begin
                state_d = TFS_RESET;
            end
        endcase
        if (soft_reset_i) begin
            state_d = TFS_RESET;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_q    <= TFS_RESET;
            hold_cnt_q <= 8'h00;
            rd_dly_q   <= 1'b0;
            wr_dly_q   <= 1'b0;
        end else begin
            state_q  <= state_d;
            rd_dly_q <= rd_s;
            wr_dly_q <= wr_s;
            if (state_q != TFS_RESET || soft_reset_i) begin
                hold_cnt_q <= 8'h00;
            end else if (!hold_done) begin
                hold_cnt_q <= hold_cnt_q + 8'h01;
            end
        end
    end

    // Task file parameters; error results freeze until a new command, a soft reset or a host count or sector write.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            feature_q  <= REG_RESET_VAL;
            count_q    <= COUNT_RESET_VAL;
            sector_q   <= SECT_RESET_VAL;
            err_code_q <= ERRREG_RESET;
            err_q      <= 1'b0;
        end else begin
            if (wr_feat) begin
                feature_q <= dd_s;
            end
            if (wr_count) begin
                count_q <= dd_s;
            end else if (done_err) begin
                count_q <= core_left_count_i;
            end
            if (wr_sect) begin
                sector_q <= dd_s;
            end else if (done_err) begin
                sector_q <= core_error_sector_i;
            end
            if (done_ev) begin
                err_code_q <= core_error_code_i;
            end
            if (soft_reset_i || wr_cmd) begin
                err_q <= 1'b0;
            end else if (done_ev) begin
                err_q <= core_error_i;
            end
        end
    end

    // Command hand-off to the device core.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cmd_valid_q   <= 1'b0;
            cmd_code_q    <= REG_RESET_VAL;
            cmd_feature_q <= REG_RESET_VAL;
            cmd_count_q   <= FULL_SECT_COUNT;
            cmd_sector_q  <= REG_RESET_VAL;
            cmd_lba_q     <= 1'b0;
        end else begin
            cmd_valid_q <= wr_cmd;
            if (wr_cmd) begin
                cmd_code_q    <= dd_s;
                cmd_feature_q <= feature_q;
                cmd_count_q   <= sect_total(count_q);
                cmd_sector_q  <= sector_q;
                cmd_lba_q     <= lba_mode_i;
            end
        end
    end

    // Interrupt pending: a new event in the read cycle wins.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            intr_q <= 1'b0;
        end else if (soft_reset_i) begin
            intr_q <= 1'b0;
        end else if (done_ev || blk_ready) begin
            intr_q <= 1'b1;
        end else if (rd_status) begin
            intr_q <= 1'b0;
        end
    end

    tfs_flag_hold #(
        .LOCK_ON_CHANGE (1'b1)
    ) u_ready (
        .ref_clk_i     (ref_clk_i),
        .rstn_i        (rstn_i),
        .live_i        (core_ready_i),
        .freeze_i      (1'b0),
        .status_read_i (rd_status),
        .flag_o        (ready_flag)
    );

    tfs_flag_hold #(
        .LOCK_ON_CHANGE (1'b0)
    ) u_seek (
        .ref_clk_i     (ref_clk_i),
        .rstn_i        (rstn_i),
        .live_i        (core_seek_done_i),
        .freeze_i      (done_err),
        .status_read_i (rd_status),
        .flag_o        (seek_flag)
    );

    // Status image; with busy set only busy is shown.
    assign status = busy ? 8'h80 : {1'b0, ready_flag, core_fault_i,
                    seek_flag, data_request_flag, core_corrected_i, core_index_i,
                    err_q};
    assign rd_hit = (da_s == DA_FEATURE) || (da_s == DA_SECT_COUNT)
                    || (da_s == DA_SECT_NUMBER) || (da_s == DA_STATUS);
    assign rd_mux = (da_s == DA_FEATURE)     ? err_code_q :
                    (da_s == DA_SECT_COUNT)  ? count_q :
                    (da_s == DA_SECT_NUMBER) ? sector_q :
                    (da_s == DA_STATUS)      ? status : 8'h00;

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_q <= 8'h00;
        end else if (rd_ev) begin
            // Taken once per strobe so a flag released by this read still
            // shows its held value to the host.
            rdata_q <= rd_mux;
        end
    end

    assign host_dd_o      = rdata_q;
    assign host_dd_oe_o   = rd_s && rd_dly_q && sel && rd_hit;
    assign host_intrq_o   = intr_q;
    assign busy_o         = busy;
    assign data_request_o = data_request_flag;
    assign cmd_valid_o    = cmd_valid_q;
    assign cmd_code_o     = cmd_code_q;
    assign cmd_feature_o  = cmd_feature_q;
    assign cmd_count_o    = cmd_count_q;
    assign cmd_sector_o   = cmd_sector_q;
    assign cmd_lba_o      = cmd_lba_q;

    // Checks.
    localparam int BUSY_LIM = BUSY_MAX_CYC;
    logic cmd_open_q;

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cmd_open_q <= 1'b0;
        end else if (wr_cmd) begin
            cmd_open_q <= 1'b1;
        end else if (done_ev || final_in || soft_reset_i) begin
            cmd_open_q <= 1'b0;
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);

    property p_busy_after_cmd;
        wr_cmd |-> ##[1:BUSY_LIM] busy;
    endproperty
    a_busy_after_cmd: assert property (p_busy_after_cmd)
        else $error("busy not raised after command write");

    property p_busy_after_soft_reset_bit;
        soft_reset_i |=> busy;
    endproperty
    a_busy_after_soft_reset_bit: assert property (p_busy_after_soft_reset_bit)
        else $error("busy not raised by soft reset");

    property p_open_cmd;
        cmd_open_q |-> (busy || data_request_flag);
    endproperty
    a_open_cmd: assert property (p_open_cmd)
        else $error("neither busy nor data request during command");

    property p_busy_write_ignored;
        (wr_ev && busy && da_s == DA_SECT_COUNT) |=> $stable(count_q);
    endproperty
    a_busy_write_ignored: assert property (p_busy_write_ignored)
        else $error("count changed by write while busy");

    property p_drq_change;
        ($changed(data_request_flag) && !busy && !$past(busy)) |-> $past(final_in);
    endproperty
    a_drq_change: assert property (p_drq_change)
        else $error("data request changed while not busy");

    property p_err_frozen;
        (err_q && !wr_cmd && !soft_reset_i && !wr_count && !wr_sect)
            |=> (err_q && $stable(count_q) && $stable(sector_q)
                 && $stable(err_code_q));
    endproperty
    a_err_frozen: assert property (p_err_frozen)
        else $error("error context changed while frozen");

    property p_status_read_clears;
        (rd_status && !done_ev && !blk_ready && !soft_reset_i)
            |=> !host_intrq_o;
    endproperty
    a_status_read_clears: assert property (p_status_read_clears)
        else $error("status read did not clear interrupt");

    property p_ready_hold;
        ($changed(ready_flag) && !rd_status) |=> $stable(ready_flag);
    endproperty
    a_ready_hold: assert property (p_ready_hold)
        else $error("ready changed twice without status read");

    property p_count_zero;
        (wr_cmd && count_q == 8'h00) |=> (cmd_count_o == FULL_SECT_COUNT);
    endproperty
    a_count_zero: assert property (p_count_zero)
        else $error("zero count not passed as full count");

    property p_err_load;
        done_err |=> (count_q == $past(core_left_count_i)
                      && sector_q == $past(core_error_sector_i) && err_q);
    endproperty
    a_err_load: assert property (p_err_load)
        else $error("error completion did not load context");

    c_cmd_done: cover property (wr_cmd ##[1:20] done_ev);
    c_pio_in: cover property (blk_ready ##[1:20] final_in);
    c_err: cover property (done_err ##[1:20] rd_status);
endmodule

// >>> tb/tfs_host_model.sv
`timescale 1ns/1ps
// Host adapter model that runs read and write cycles on the pins.
module tfs_host_model
    import tfs_pkg::*;
(
    // Clock.
    input  wire logic       ref_clk_i,
    // Device side view.
    input  wire logic [7:0] dev_dd_i,
    input  wire logic       dev_oe_i,
    input  wire logic       busy_i,
    input  wire logic       drq_i,
    // Host bus pins.
    output logic      [1:0] cs_o,
    output logic      [2:0] da_o,
    output logic            rd_o,
    output logic            wr_o,
    output logic      [7:0] dd_o,
    // Captured read, output enable on top.
    output logic            rd_valid_o,
    output logic      [8:0] rd_data_o
);
    initial begin
        cs_o       = 2'h0;
        da_o       = 3'h0;
        rd_o       = 1'b0;
        wr_o       = 1'b0;
        dd_o       = 8'h00;
        rd_valid_o = 1'b0;
        rd_data_o  = 9'h000;
    end

    task automatic wr(input logic [2:0] a, input logic [7:0] d,
                      input bit obey);
        int n;
        n = 0;
        while (obey && (busy_i !== 1'b0 || drq_i !== 1'b0)
               && n < 400) begin
            @(posedge ref_clk_i);
            n++;
        end
        @(posedge ref_clk_i);
        cs_o <= CS_CMD_BLK;
        da_o <= a;
        dd_o <= d;
        wr_o <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        wr_o <= 1'b0;
        cs_o <= 2'h0;
        dd_o <= ~d;
        repeat (4) @(posedge ref_clk_i);
    endtask

    task automatic rd(input logic [2:0] a);
        repeat (BUSY_MAX_CYC) @(posedge ref_clk_i);
        cs_o <= CS_CMD_BLK;
        da_o <= a;
        rd_o <= 1'b1;
        repeat (6) @(posedge ref_clk_i);
        rd_valid_o <= 1'b1;
        rd_data_o  <= {dev_oe_i, dev_dd_i};
        rd_o       <= 1'b0;
        cs_o       <= 2'h0;
        @(posedge ref_clk_i);
        rd_valid_o <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
    endtask
endmodule

// >>> tb/testbench.sv
`timescale 1ns/1ps
// Self-checking bench for the command block registers.
module testbench;
    import tfs_pkg::*;

    logic        ref_clk_i, rstn_i, soft_reset_i, lba_mode_i;
    logic        c_rdy, c_seek, c_brdy, c_btak, c_last, c_dir, c_done, c_err;
    logic        c_flt, c_cor, c_idx;
    logic [7:0]  c_code, c_left, c_esec, host_dd_o, cmd_code_o, cmd_feature_o;
    logic [7:0]  cmd_sector_o, h_dd, s;
    logic [8:0]  cmd_count_o, h_rdat;
    logic [1:0]  h_cs;
    logic [2:0]  h_da;
    logic        h_rd, h_wr, h_rv, host_dd_oe_o, host_intrq_o, cmd_valid_o;
    logic        cmd_lba_o, busy_o, data_request_o;
    logic [8:0]  exp_rd[$];
    logic [33:0] exp_cmd[$];
    int          error_cnt, tests_run, cyc;

    tfs_task_file #(.RESET_HOLD(2)) dut (
        .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .host_cs_i(h_cs),
        .host_da_i(h_da), .host_rd_i(h_rd), .host_wr_i(h_wr),
        .host_dd_i(h_dd), .host_dd_o(host_dd_o),
        .host_dd_oe_o(host_dd_oe_o), .host_intrq_o(host_intrq_o),
        .soft_reset_i(soft_reset_i), .lba_mode_i(lba_mode_i),
        .core_ready_i(c_rdy), .core_fault_i(c_flt),
        .core_seek_done_i(c_seek), .core_corrected_i(c_cor),
        .core_index_i(c_idx), .core_block_ready_i(c_brdy),
        .core_block_taken_i(c_btak), .core_last_block_i(c_last),
        .core_dir_in_i(c_dir), .core_done_i(c_done), .core_error_i(c_err),
        .core_error_code_i(c_code), .core_left_count_i(c_left),
        .core_error_sector_i(c_esec), .cmd_valid_o(cmd_valid_o),
        .cmd_code_o(cmd_code_o), .cmd_feature_o(cmd_feature_o),
        .cmd_count_o(cmd_count_o), .cmd_sector_o(cmd_sector_o),
        .cmd_lba_o(cmd_lba_o), .busy_o(busy_o),
        .data_request_o(data_request_o));

    tfs_host_model host (
        .ref_clk_i(ref_clk_i), .dev_dd_i(host_dd_o), .dev_oe_i(host_dd_oe_o),
        .busy_i(busy_o), .drq_i(data_request_o), .cs_o(h_cs), .da_o(h_da),
        .rd_o(h_rd), .wr_o(h_wr), .dd_o(h_dd), .rd_valid_o(h_rv),
        .rd_data_o(h_rdat));

    initial begin
        ref_clk_i = 1'b0;
        forever #4 ref_clk_i = ~ref_clk_i;
    end

    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction

    task automatic close_out();
        $display("errors %0d comparisons %0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic fail(input string m);
        error_cnt++;
        $display("[FAIL] %0t %s", $time, m);
    endtask

    task automatic cmp_rd(input logic [8:0] g, input logic [8:0] e);
        tests_run++;
        if (g !== e) fail($sformatf("read %h expected %h", g, e));
    endtask

    task automatic cmp_cmd(input logic [33:0] g, input logic [33:0] e);
        tests_run++;
        if (g !== e) fail($sformatf("command %h expected %h", g, e));
    endtask

    task automatic cmp_lvl(input logic g, input logic e);
        tests_run++;
        if (g !== e) fail($sformatf("level %b expected %b", g, e));
    endtask

    task automatic rd_exp(input logic [2:0] a, input logic [8:0] e);
        exp_rd.push_back(e);
        host.rd(a);
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        while (busy_o !== 1'b0 && n < 300) begin
            @(posedge ref_clk_i);
            n++;
        end
        cmp_lvl(busy_o, 1'b0);
    endtask

    task automatic cmd(input logic [7:0] c, input logic [7:0] f,
                       input logic [7:0] n, input logic [7:0] q,
                       input logic l);
        lba_mode_i <= l;
        host.wr(DA_FEATURE, f, 1'b1);
        host.wr(DA_SECT_COUNT, n, 1'b1);
        host.wr(DA_SECT_NUMBER, q, 1'b1);
        exp_cmd.push_back({c, f, (n == 8'h00) ? FULL_SECT_COUNT
                                              : {1'b0, n}, q, l});
        host.wr(DA_STATUS, c, 1'b1);
        cmp_lvl(busy_o, 1'b1);
    endtask

    // Pulse 0 block ready, 1 block taken, 2 command done.
    task automatic ev(input int k, input logic a, input logic b);
        @(posedge ref_clk_i);
        c_brdy <= (k == 0);
        c_btak <= (k == 1);
        c_done <= (k == 2);
        c_err  <= a;
        c_last <= a;
        c_dir  <= b;
        @(posedge ref_clk_i);
        {c_brdy, c_btak, c_done, c_err} <= 4'h0;
        repeat (2) @(posedge ref_clk_i);
    endtask

    always @(posedge ref_clk_i) begin
        if (cmd_valid_o === 1'b1) begin
            if (exp_cmd.size() == 0) fail("command not expected");
            else cmp_cmd({cmd_code_o, cmd_feature_o, cmd_count_o,
                          cmd_sector_o, cmd_lba_o}, exp_cmd.pop_front());
        end
        if (h_rv === 1'b1) begin
            if (exp_rd.size() == 0) fail("read not expected");
            else cmp_rd(h_rdat, exp_rd.pop_front());
        end
        cyc++;
        if (cyc == 20000) begin
            fail("timeout");
            close_out();
        end
    end

    initial begin
        {rstn_i, soft_reset_i, lba_mode_i, c_brdy, c_btak} = 5'h00;
        {c_last, c_dir, c_done, c_err} = 4'h0;
        {c_rdy, c_seek} = 2'h3;
        {c_flt, c_cor, c_idx} = 3'h0;
        {c_code, c_left, c_esec} = 24'h000000;
        error_cnt = 0;
        tests_run = 0;
        cyc = 0;
        s = 8'h18;
        repeat (4) @(posedge ref_clk_i);
        rstn_i <= 1'b1;
        wait_idle();
        rd_exp(DA_STATUS, 9'h150);
        rd_exp(DA_FEATURE, {1'b1, ERRREG_RESET});
        rd_exp(DA_SECT_COUNT, {1'b1, COUNT_RESET_VAL});
        rd_exp(3'h4, 9'h000);
        s = lfsr(s);
        cmd(s, lfsr(s), 8'h00, ~s, 1'b1);
        host.wr(DA_SECT_COUNT, 8'h77, 1'b0);
        host.wr(DA_STATUS, 8'h20, 1'b0);
        s = lfsr(s);
        {c_code, c_left, c_esec} <= {s, lfsr(s), ~s};
        ev(2, 1'b1, 1'b0);
        cmp_lvl(host_intrq_o, 1'b1);
        c_seek <= 1'b0;
        rd_exp(DA_STATUS, 9'h151);
        cmp_lvl(host_intrq_o, 1'b0);
        rd_exp(DA_STATUS, 9'h141);
        c_seek <= 1'b1;
        rd_exp(DA_SECT_COUNT, {1'b1, lfsr(s)});
        rd_exp(DA_SECT_NUMBER, {1'b1, ~s});
        rd_exp(DA_FEATURE, {1'b1, s});
        cmd(8'h20, 8'h00, 8'h01, 8'h05, 1'b0);
        ev(0, 1'b0, 1'b0);
        cmp_lvl(data_request_o, 1'b1);
        cmp_lvl(busy_o, 1'b0);
        c_cor <= 1'b1;
        rd_exp(DA_STATUS, 9'h15c);
        cmp_lvl(data_request_o, 1'b1);
        c_cor <= 1'b0;
        ev(1, 1'b1, 1'b1);
        cmp_lvl(data_request_o, 1'b0);
        cmp_lvl(busy_o, 1'b0);
        cmd(8'h30, 8'h00, 8'h02, 8'hff, 1'b1);
        ev(0, 1'b0, 1'b0);
        ev(1, 1'b0, 1'b0);
        cmp_lvl(busy_o, 1'b1);
        cmp_lvl(data_request_o, 1'b0);
        ev(2, 1'b0, 1'b0);
        {c_flt, c_idx} <= 2'h3;
        rd_exp(DA_STATUS, 9'h172);
        {c_flt, c_idx} <= 2'h0;
        soft_reset_i <= 1'b1;
        @(posedge ref_clk_i);
        @(posedge ref_clk_i);
        cmp_lvl(busy_o, 1'b1);
        soft_reset_i <= 1'b0;
        wait_idle();
        rd_exp(DA_STATUS, 9'h150);
        repeat (20) @(posedge ref_clk_i);
        if (exp_rd.size() != 0 || exp_cmd.size() != 0) begin
            fail("results missing");
        end
        close_out();
    end
endmodule
